// *** include/cod_pkg.sv ***
package cod_pkg;
    // object indices
    localparam logic [15:0] IDX_DEVTYPE  = 16'h1000;
    localparam logic [15:0] IDX_ERRCAT   = 16'h1001;
    localparam logic [15:0] IDX_ERRLOG   = 16'h1003;
    localparam logic [15:0] IDX_SYNCID   = 16'h1005;
    localparam logic [15:0] IDX_NAME     = 16'h1008;
    localparam logic [15:0] IDX_HWVER    = 16'h1009;
    localparam logic [15:0] IDX_SWVER    = 16'h100A;
    localparam logic [15:0] IDX_GUARD    = 16'h100C;
    localparam logic [15:0] IDX_LIFEMUL  = 16'h100D;
    localparam logic [15:0] IDX_SAVE     = 16'h1010;
    localparam logic [15:0] IDX_RESTORE  = 16'h1011;
    localparam logic [15:0] IDX_EMCYID   = 16'h1014;
    localparam logic [15:0] IDX_HBWATCH  = 16'h1016;
    localparam logic [15:0] IDX_HBSEND   = 16'h1017;
    // reset values and constants
    localparam logic [31:0] SYNC_ID_RST  = 32'h0000_0080;
    localparam logic [31:0] EMCY_ID_BASE = 32'h0000_0080;
    localparam logic [31:0] SIG_SAVE     = 32'h6576_6173;
    localparam logic [31:0] SIG_LOAD     = 32'h6461_6F6C;
    localparam logic [31:0] CAPABLE      = 32'h0000_0001;
    localparam logic [7:0]  SAVE_SUBS    = 8'h03;
    localparam logic [7:0]  RESTORE_SUBS = 8'h06;
    localparam logic [7:0]  SAVE_COUNT   = 8'h09;
    localparam logic [7:0]  HBW_COUNT    = 8'h01;
    localparam logic [7:0]  LOG_DEPTH    = 8'h02;
    // abort code for bad access
    localparam logic [31:0] ABORT_CODE   = 32'h0601_0000;
    // time base
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          MS_PER_S     = 1000;
    localparam int          MS_CYCLES    = CLK_HZ / MS_PER_S;
    // host register offsets
    localparam logic [3:0]  HR_CMD       = 4'h0;
    localparam logic [3:0]  HR_WDATA     = 4'h1;
    localparam logic [3:0]  HR_RDATA     = 4'h2;
    localparam logic [3:0]  HR_STATUS    = 4'h3;
    localparam logic [3:0]  HR_IRQ      = 4'h4;
    localparam logic [3:0]  HR_MASK      = 4'h5;
    localparam logic [3:0]  HR_LIVE      = 4'h6;
    // host command field layout and master state encoding
    localparam int          CMD_WR_BIT   = 24;
    typedef enum logic [2:0] {
        COD_IDLE = 3'b001,
        COD_REQ  = 3'b010,
        COD_WAIT = 3'b100
    } cod_host_st_t;
endpackage

// *** include/cod_if.sv ***
`timescale 1ns/100ps
// object access channel between master and dictionary
interface cod_if;
    logic        req;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
    logic        live;
    modport dev (input req, wr, index, sub, wdata, live, output ack, abort, rdata);
    modport mst (output req, wr, index, sub, wdata, live, input ack, abort, rdata);
endinterface

// *** logic/cod_dict.sv ***
`timescale 1ns/100ps
// Function
// - device type word: two 16-bit halves, read-only
// - read-only 8-bit error category register
// - error log: count, newest, previous entries
// - writing zero to count clears log
// - sync identifier writable, resets to 0x80
// - master reads text entries by segmented transfers; here every access to them aborts
// - guard interval 16-bit ms, zero disables
// - lifetime equals multiplier times guard interval
// - save signature on sub 1-3 starts save
// - save subs read 1; signature 'save'
// - load signature on sub 1-6 starts restore
// - restore subs read capability; signature 'load'
// - factory restore only with output stage off
// - emergency identifier resets to 0x80 plus node
// - heartbeat watch bits 0-15 ms, zero off
// - bits 16-23 master node, 24-31 reserved
// - heartbeat send interval 16-bit ms, zero off
// - master should avoid frequent save commands
module cod_dict
    import cod_pkg::*;
#(
    parameter logic [15:0] TYPE_INFO  = 16'h0001,  // arbitrary value
    parameter logic [15:0] PROFILE_NO = 16'h0001,  // arbitrary value
    parameter int          MS_CYC     = MS_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    cod_if.dev               bus,
    input  wire logic [6:0]  node_id,
    input  wire logic [7:0]  error_categories,
    input  wire logic        error_push,
    input  wire logic [31:0] error_code,
    input  wire logic        stage_enabled,
    input  wire logic        nv_busy,
    output logic             save_start_q,
    output logic [1:0]       save_scope_q,
    output logic             restore_start_q,
    output logic [2:0]       restore_scope_q,
    output logic             comm_error_q,
    output logic             heartbeat_tick_q,
    output logic [31:0]      sync_id_q,
    output logic [31:0]      emcy_id_q
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] guard_q;
    logic [7:0]  lifemul_q;
    logic [31:0] hbwatch_q;
    logic [15:0] hbsend_q;
    logic [1:0]  log_cnt_q;
    logic [31:0] log0_q;
    logic [31:0] log1_q;
    logic [7:0]  errcat_q;
    logic        ack_q;
    logic        abort_q;
    logic [31:0] rdata_q;
    logic        emcy_set_q;
    logic        stage_s1_q;
    logic        stage_s2_q;
    logic        live_prev_q;
    logic [14:0] pre_q;
    logic [23:0] life_ms_q;
    logic [15:0] hbw_ms_q;
    logic [15:0] hbs_ms_q;

    wire         wr_go   = bus.req & bus.wr;
    wire         rd_go   = bus.req & ~bus.wr;
    wire         sub0    = bus.sub == 8'h00;
    wire [23:0]  life_ms = guard_q * lifemul_q;
    wire         guard_on = (guard_q != 16'h0000) && (lifemul_q != 8'h00);
    wire [15:0]  hbw_time = hbwatch_q[15:0];
    wire         hbw_on   = hbw_time != 16'h0000;
    wire         ms_tick  = pre_q == 15'(MS_CYC - 1);
    wire         live_in  = bus.live;
    wire         live_evt = live_in & ~live_prev_q;
    wire         save_hit = wr_go && bus.index == IDX_SAVE && bus.sub != 8'h00
                            && bus.sub <= SAVE_SUBS && bus.wdata == SIG_SAVE;
    wire         rest_sub = bus.sub != 8'h00 && bus.sub <= RESTORE_SUBS;
    wire         factory  = bus.sub <= 8'h03;
    wire         rest_hit = wr_go && bus.index == IDX_RESTORE && rest_sub
                            && bus.wdata == SIG_LOAD
                            && !(factory && stage_s2_q);
    wire         wr_ok;
    wire [31:0]  rd_val;
    wire         rd_ok;
    wire         rd_val_ok;

    // writable objects and trigger acceptance
    assign wr_ok = (bus.index == IDX_SYNCID && sub0)
                || (bus.index == IDX_EMCYID && sub0)
                || (bus.index == IDX_GUARD && sub0)
                || (bus.index == IDX_LIFEMUL && sub0)
                || (bus.index == IDX_HBSEND && sub0)
                || (bus.index == IDX_HBWATCH && bus.sub == 8'h01)
                || (bus.index == IDX_ERRLOG && sub0 && bus.wdata == 32'h0000_0000)
                || (save_hit && !nv_busy)
                || (rest_hit && !nv_busy);

    // read decode
    assign rd_ok = !(bus.index == IDX_NAME || bus.index == IDX_HWVER
                     || bus.index == IDX_SWVER) && rd_val_ok;
    assign rd_val_ok = (bus.index == IDX_DEVTYPE && sub0)
                    || (bus.index == IDX_ERRCAT && sub0)
                    || (bus.index == IDX_ERRLOG && bus.sub <= {6'h00, log_cnt_q})
                    || (bus.index == IDX_SYNCID && sub0)
                    || (bus.index == IDX_GUARD && sub0)
                    || (bus.index == IDX_LIFEMUL && sub0)
                    || (bus.index == IDX_SAVE && bus.sub <= SAVE_SUBS)
                    || (bus.index == IDX_RESTORE && bus.sub <= RESTORE_SUBS)
                    || (bus.index == IDX_EMCYID && sub0)
                    || (bus.index == IDX_HBWATCH && bus.sub <= 8'h01)
                    || (bus.index == IDX_HBSEND && sub0);

    assign rd_val =
        (bus.index == IDX_DEVTYPE) ? {TYPE_INFO, PROFILE_NO} :
        (bus.index == IDX_ERRCAT)  ? {24'h000000, errcat_q} :
        (bus.index == IDX_ERRLOG)  ? (sub0 ? {30'h0, log_cnt_q} :
                                      (bus.sub == 8'h01) ? log0_q : log1_q) :
        (bus.index == IDX_SYNCID)  ? sync_id_q :
        (bus.index == IDX_GUARD)   ? {16'h0000, guard_q} :
        (bus.index == IDX_LIFEMUL) ? {24'h000000, lifemul_q} :
        (bus.index == IDX_SAVE)    ? (sub0 ? {24'h0, SAVE_COUNT} : CAPABLE) :
        (bus.index == IDX_RESTORE) ? (sub0 ? {24'h0, RESTORE_SUBS} : CAPABLE) :
        (bus.index == IDX_EMCYID)  ? emcy_id_q :
        (bus.index == IDX_HBWATCH) ? (sub0 ? {24'h0, HBW_COUNT}
                                           : {8'h00, hbwatch_q[23:0]}) :
        {16'h0000, hbsend_q};

    assign bus.ack   = ack_q;
    assign bus.abort = abort_q;
    assign bus.rdata = rdata_q;

    ////////////////////////////////////////////////////////////////
    // access answer, one cycle after request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            abort_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= bus.req;
            abort_q <= bus.req & (bus.wr ? ~wr_ok : ~rd_ok);
            rdata_q <= (rd_go && rd_ok) ? rd_val : 32'h0000_0000;
        end
    end

    // configuration objects
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_id_q  <= SYNC_ID_RST;
            emcy_id_q  <= 32'h0000_0000;
            emcy_set_q <= 1'b0;
            guard_q    <= 16'h0000;
            lifemul_q  <= 8'h00;
            hbwatch_q  <= 32'h0000_0000;
            hbsend_q   <= 16'h0000;
        end else begin
            if (!emcy_set_q) begin
                emcy_id_q  <= EMCY_ID_BASE + {25'h0, node_id};
                emcy_set_q <= 1'b1;
            end
            if (wr_go && wr_ok && sub0) begin
                if (bus.index == IDX_SYNCID) sync_id_q <= bus.wdata;
                if (bus.index == IDX_EMCYID) emcy_id_q <= bus.wdata;
                if (bus.index == IDX_GUARD) guard_q <= bus.wdata[15:0];
                if (bus.index == IDX_LIFEMUL) lifemul_q <= bus.wdata[7:0];
                if (bus.index == IDX_HBSEND) hbsend_q <= bus.wdata[15:0];
            end
            if (wr_go && bus.index == IDX_HBWATCH && bus.sub == 8'h01)
                hbwatch_q <= {8'h00, bus.wdata[23:0]};
        end
    end

    // error category and history; push wins over clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            errcat_q  <= 8'h00;
            log_cnt_q <= 2'b00;
            log0_q    <= 32'h0000_0000;
            log1_q    <= 32'h0000_0000;
        end else begin
            errcat_q <= error_categories;
            if (error_push) begin
                log0_q <= error_code;
                log1_q <= log0_q;
                if (log_cnt_q != LOG_DEPTH[1:0]) log_cnt_q <= log_cnt_q + 2'b01;
            end else if (wr_go && bus.index == IDX_ERRLOG && sub0
                         && bus.wdata == 32'h0000_0000) begin
                log_cnt_q <= 2'b00;
                log0_q    <= 32'h0000_0000;
                log1_q    <= 32'h0000_0000;
            end
        end
    end

    // save and restore triggers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            save_start_q    <= 1'b0;
            save_scope_q    <= 2'b00;
            restore_start_q <= 1'b0;
            restore_scope_q <= 3'b000;
            stage_s1_q      <= 1'b0;
            stage_s2_q      <= 1'b0;
        end else begin
            stage_s1_q      <= stage_enabled;
            stage_s2_q      <= stage_s1_q;
            save_start_q    <= save_hit & ~nv_busy;
            restore_start_q <= rest_hit & ~nv_busy;
            if (save_hit && !nv_busy) save_scope_q <= bus.sub[1:0];
            if (rest_hit && !nv_busy) restore_scope_q <= bus.sub[2:0];
        end
    end

    // millisecond timers: lifetime, heartbeat watch, heartbeat send
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pre_q            <= 15'h0000;
            live_prev_q      <= 1'b0;
            life_ms_q        <= 24'h000000;
            hbw_ms_q         <= 16'h0000;
            hbs_ms_q         <= 16'h0000;
            comm_error_q     <= 1'b0;
            heartbeat_tick_q <= 1'b0;
        end else begin
            pre_q            <= ms_tick ? 15'h0000 : pre_q + 15'h0001;
            live_prev_q      <= live_in;
            comm_error_q     <= 1'b0;
            heartbeat_tick_q <= 1'b0;
            if (live_evt || !guard_on) life_ms_q <= 24'h000000;
            else if (ms_tick) begin
                if (life_ms_q + 24'h000001 >= life_ms) begin
                    comm_error_q <= 1'b1;
                    life_ms_q    <= 24'h000000;
                end else life_ms_q <= life_ms_q + 24'h000001;
            end
            if (live_evt || !hbw_on) hbw_ms_q <= 16'h0000;
            else if (ms_tick) begin
                if (hbw_ms_q + 16'h0001 >= hbw_time) begin
                    comm_error_q <= 1'b1;
                    hbw_ms_q     <= 16'h0000;
                end else hbw_ms_q <= hbw_ms_q + 16'h0001;
            end
            if (hbsend_q == 16'h0000) hbs_ms_q <= 16'h0000;
            else if (ms_tick) begin
                if (hbs_ms_q + 16'h0001 >= hbsend_q) begin
                    heartbeat_tick_q <= 1'b1;
                    hbs_ms_q         <= 16'h0000;
                end else hbs_ms_q <= hbs_ms_q + 16'h0001;
            end
        end
    end
endmodule

// *** logic/cod_master.sv ***
`timescale 1ns/100ps
module cod_master
    import cod_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    cod_if.mst               bus,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_q,
    output logic             irq_q
);
    ////////////////////////////////////////////////////////////////
    cod_host_st_t st_q;
    logic [31:0]  cmd_q;
    logic [31:0]  wdat_q;
    logic [31:0]  rdat_q;
    logic         abort_q;
    logic [1:0]   stat_q;
    logic [1:0]   mask_q;
    logic         live_q;
    logic         req_q;

    wire go      = reg_wr && reg_addr == HR_CMD && st_q == COD_IDLE;
    wire done    = st_q == COD_WAIT && bus.ack;
    wire irq_rd  = reg_rd && reg_addr == HR_IRQ;
    wire [1:0] ev = {done & bus.abort, done};
    wire [31:0] rd_mux =
        (reg_addr == HR_CMD)    ? cmd_q :
        (reg_addr == HR_WDATA)  ? wdat_q :
        (reg_addr == HR_RDATA)  ? rdat_q :
        (reg_addr == HR_STATUS) ? {30'h0, abort_q, st_q != COD_IDLE} :
        (reg_addr == HR_IRQ)    ? {30'h0, stat_q} :
        (reg_addr == HR_MASK)   ? {30'h0, mask_q} :
        (reg_addr == HR_LIVE)   ? {31'h0, live_q} : 32'h0000_0000;

    assign bus.req   = req_q;
    assign bus.wr    = cmd_q[CMD_WR_BIT];
    assign bus.index = cmd_q[15:0];
    assign bus.sub   = cmd_q[23:16];
    assign bus.wdata = wdat_q;
    assign bus.live  = live_q;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q        <= COD_IDLE;
            cmd_q       <= 32'h0000_0000;
            wdat_q      <= 32'h0000_0000;
            rdat_q      <= 32'h0000_0000;
            abort_q     <= 1'b0;
            stat_q      <= 2'b00;
            mask_q      <= 2'b00;
            live_q      <= 1'b0;
            req_q       <= 1'b0;
            reg_rdata_q <= 32'h0000_0000;
            irq_q       <= 1'b0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
            stat_q      <= ev | (irq_rd ? 2'b00 : stat_q);
            irq_q       <= |((ev | (irq_rd ? 2'b00 : stat_q)) & mask_q);
            if (reg_wr && reg_addr == HR_WDATA) wdat_q <= reg_wdata;
            if (reg_wr && reg_addr == HR_MASK) mask_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == HR_LIVE) live_q <= reg_wdata[0];
            case (st_q)
                COD_IDLE: begin
                    if (go) begin
                        cmd_q <= reg_wdata;
                        req_q <= 1'b1;
                        st_q  <= COD_REQ;
                    end
                end
                COD_REQ: begin
                    req_q <= 1'b0;
                    st_q  <= COD_WAIT;
                end
                COD_WAIT: begin
                    if (bus.ack) begin
                        rdat_q  <= bus.rdata;
                        abort_q <= bus.abort;
                        st_q    <= COD_IDLE;
                    end
                end
                default: st_q <= COD_IDLE;
            endcase
        end
    end
endmodule

// *** dv/cod_assertions.sv ***
`timescale 1ns/100ps
module cod_assertions
    import cod_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [15:0] index,
    input wire logic [7:0]  sub,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic        abort,
    input wire logic [31:0] rdata,
    input wire logic        live
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_ack_follows_req:
        assert property (req |=> ack) else $error("no ack after request");
    a_no_stray_ack:
        assert property (ack |-> $past(req)) else $error("ack without request");
    a_abort_with_ack:
        assert property (abort |-> ack) else $error("abort outside ack");
    a_devtype_ro:
        assert property (req && wr && index == IDX_DEVTYPE |=> abort)
        else $error("device type write accepted");
    a_errcat_ro:
        assert property (req && wr && index == IDX_ERRCAT |=> abort)
        else $error("error category write accepted");
    a_log_entries_ro:
        assert property (req && wr && index == IDX_ERRLOG && sub != 8'h00 |=> abort)
        else $error("error entry write accepted");
    a_text_refused:
        assert property (req && index >= IDX_NAME && index <= IDX_SWVER |=> ack && abort)
        else $error("text object served in one word");
    a_save_sig_bad:
        assert property (req && wr && index == IDX_SAVE && sub inside {[1:3]}
                         && wdata != SIG_SAVE |=> abort)
        else $error("bad save signature accepted");
    a_load_sig_bad:
        assert property (req && wr && index == IDX_RESTORE && sub inside {[1:6]}
                         && wdata != SIG_LOAD |=> abort)
        else $error("bad load signature accepted");
    a_save_capable:
        assert property (req && !wr && index == IDX_SAVE && sub inside {[1:3]}
                         |=> !abort && rdata == CAPABLE)
        else $error("save capability wrong");
    a_restore_capable:
        assert property (req && !wr && index == IDX_RESTORE && sub inside {[1:6]}
                         |=> !abort && rdata == CAPABLE)
        else $error("restore capability wrong");
endmodule

// *** dv/canopen_comm_object_dictionary_tb.sv ***
`timescale 1ns/100ps
module canopen_comm_object_dictionary_tb;
    import cod_pkg::*;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, error_push = 0;
    logic stage_enabled = 0, nv_busy = 0, irq_q;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata_q, error_code = 0, sync_id_q, emcy_id_q;
    logic [7:0]  error_categories = 0;
    logic        save_start_q, restore_start_q, comm_error_q, heartbeat_tick_q;
    logic [1:0]  save_scope_q;
    logic [2:0]  restore_scope_q;
    int n_errors = 0, n_tests = 0, n_save = 0, n_rest = 0, n_comm = 0, n_tick = 0, cyc = 0;
    logic [2:0]  last_scope;
    localparam logic [15:0] TB_INFO = 16'h00A1;  // arbitrary value
    localparam logic [15:0] TB_PROF = 16'h00B2;  // arbitrary value
    cod_if link ();
    cod_dict #(.TYPE_INFO(TB_INFO), .PROFILE_NO(TB_PROF), .MS_CYC(4))
        u_cod_dict (.sys_clk(sys_clk), .rst_n(rst_n), .bus(link),
        .node_id(7'h05), .error_categories(error_categories), .error_push(error_push),
        .error_code(error_code), .stage_enabled(stage_enabled), .nv_busy(nv_busy),
        .save_start_q(save_start_q), .save_scope_q(save_scope_q),
        .restore_start_q(restore_start_q), .restore_scope_q(restore_scope_q),
        .comm_error_q(comm_error_q), .heartbeat_tick_q(heartbeat_tick_q),
        .sync_id_q(sync_id_q), .emcy_id_q(emcy_id_q));
    cod_master u_cod_master (.sys_clk(sys_clk), .rst_n(rst_n), .bus(link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));
    cod_assertions u_cod_assertions (.sys_clk(sys_clk), .rst_n(rst_n), .req(link.req),
        .wr(link.wr), .index(link.index), .sub(link.sub), .wdata(link.wdata),
        .ack(link.ack), .abort(link.abort), .rdata(link.rdata), .live(link.live));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // pulse counters for the side outputs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (save_start_q === 1'b1) begin
            n_save <= n_save + 1;
            last_scope <= {1'b0, save_scope_q};
        end
        if (restore_start_q === 1'b1) begin
            n_rest <= n_rest + 1;
            last_scope <= restore_scope_q;
        end
        if (comm_error_q === 1'b1) n_comm <= n_comm + 1;
        if (heartbeat_tick_q === 1'b1) n_tick <= n_tick + 1;
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hwr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    // read data stands in the cycle after the strobe; taken at its closing edge
    task automatic hrd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 0;
        @(posedge sys_clk);
        d = reg_rdata_q;
    endtask
    // one object access through the host command path
    task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sb,
                       input logic [31:0] wd, input logic eab, input logic [31:0] erd);
        logic [31:0] st;
        logic [31:0] rd;
        int i;
        hwr(HR_WDATA, wd);
        hwr(HR_CMD, {7'h00, w, sb, idx});
        st = 32'h1;
        i = 0;
        while (st[0] !== 1'b0 && i < 20) begin
            hrd(HR_STATUS, st);
            i++;
        end
        chk("busy", 32'h0, {31'h0, st[0]});
        chk("abort", {31'h0, eab}, {31'h0, st[1]});
        hrd(HR_RDATA, rd);
        chk("read data", (w || eab) ? 32'h0 : erd, rd);
    endtask
    task automatic live_pulse();
        hwr(HR_LIVE, 32'h1);
        hwr(HR_LIVE, 32'h0);
    endtask
    task automatic t_fixed();
        chk("sync port", SYNC_ID_RST, sync_id_q);
        chk("emcy port", EMCY_ID_BASE + 32'h5, emcy_id_q);
        obj(0, IDX_SYNCID, 0, 0, 0, SYNC_ID_RST);
        obj(0, IDX_EMCYID, 0, 0, 0, EMCY_ID_BASE + 32'h5);
        obj(0, IDX_GUARD, 0, 0, 0, 32'h0);
        obj(0, IDX_LIFEMUL, 0, 0, 0, 32'h0);
        obj(0, IDX_HBSEND, 0, 0, 0, 32'h0);
        obj(0, IDX_DEVTYPE, 0, 0, 0, {TB_INFO, TB_PROF});
        obj(1, IDX_DEVTYPE, 0, 32'h1, 1, 0);
        error_categories <= 8'hA5;
        obj(0, IDX_ERRCAT, 0, 0, 0, 32'hA5);
        obj(1, IDX_ERRCAT, 0, 32'h1, 1, 0);
        obj(0, IDX_NAME, 0, 0, 1, 0);
        obj(0, IDX_SWVER, 0, 0, 1, 0);
        obj(1, IDX_SYNCID, 0, 32'h123, 0, 0);
        obj(0, IDX_SYNCID, 0, 0, 0, 32'h123);
        chk("sync port", 32'h123, sync_id_q);
        obj(1, IDX_EMCYID, 0, 32'h99, 0, 0);
        chk("emcy port", 32'h99, emcy_id_q);
    endtask
    task automatic t_log();
        @(posedge sys_clk);
        error_push <= 1;
        error_code <= 32'h1111_2222;
        @(posedge sys_clk);
        error_code <= 32'h3333_4444;
        @(posedge sys_clk);
        error_push <= 0;
        obj(0, IDX_ERRLOG, 0, 0, 0, 32'h2);
        obj(0, IDX_ERRLOG, 1, 0, 0, 32'h3333_4444);
        obj(0, IDX_ERRLOG, 2, 0, 0, 32'h1111_2222);
        obj(1, IDX_ERRLOG, 1, 32'h0, 1, 0);
        obj(1, IDX_ERRLOG, 0, 32'h1, 1, 0);
        obj(1, IDX_ERRLOG, 0, 32'h0, 0, 0);
        obj(0, IDX_ERRLOG, 0, 0, 0, 32'h0);
    endtask
    task automatic t_save();
        for (int s = 1; s <= 3; s++) begin
            obj(0, IDX_SAVE, s[7:0], 0, 0, CAPABLE);
            obj(1, IDX_SAVE, s[7:0], SIG_SAVE, 0, 0);
            chk("save scope", s, {29'h0, last_scope});
        end
        chk("save count", 32'd3, n_save);
        obj(0, IDX_SAVE, 0, 0, 0, {24'h0, SAVE_COUNT});
        obj(1, IDX_SAVE, 1, SIG_LOAD, 1, 0);
        nv_busy <= 1;
        obj(1, IDX_SAVE, 2, SIG_SAVE, 1, 0);
        nv_busy <= 0;
        chk("save count", 32'd3, n_save);
    endtask
    task automatic t_restore();
        stage_enabled <= 1;
        repeat (4) @(posedge sys_clk);
        for (int s = 1; s <= 6; s++) begin
            obj(0, IDX_RESTORE, s[7:0], 0, 0, CAPABLE);
            obj(1, IDX_RESTORE, s[7:0], SIG_LOAD, s <= 3, 0);
            if (s > 3) chk("restore scope", s, {29'h0, last_scope});
        end
        stage_enabled <= 0;
        repeat (4) @(posedge sys_clk);
        obj(1, IDX_RESTORE, 1, SIG_SAVE, 1, 0);
        for (int s = 1; s <= 3; s++) begin
            obj(1, IDX_RESTORE, s[7:0], SIG_LOAD, 0, 0);
            chk("restore scope", s, {29'h0, last_scope});
        end
        chk("restore count", 32'd6, n_rest);
    endtask
    // counters are only read here; a base value avoids racing their update
    task automatic t_timers();
        int b;
        obj(1, IDX_LIFEMUL, 0, 32'h3, 0, 0);
        b = n_comm;
        repeat (100) @(posedge sys_clk);
        chk("guard off", 32'd0, n_comm - b);
        obj(1, IDX_GUARD, 0, 32'h2, 0, 0);
        live_pulse();
        b = n_comm;
        repeat (8) live_pulse();
        chk("guard fed", 32'd0, n_comm - b);
        b = n_comm;
        repeat (60) @(posedge sys_clk);
        chk("guard lapse", 32'd2, n_comm - b);
        obj(1, IDX_LIFEMUL, 0, 32'h0, 0, 0);
        b = n_comm;
        repeat (100) @(posedge sys_clk);
        chk("factor off", 32'd0, n_comm - b);
        obj(1, IDX_HBWATCH, 1, 32'hAB05_0002, 0, 0);
        obj(0, IDX_HBWATCH, 1, 0, 0, 32'h0005_0002);
        live_pulse();
        b = n_comm;
        repeat (30) @(posedge sys_clk);
        chk("watch lapse", 32'd1, {31'h0, (n_comm - b) inside {3, 4}});
        obj(1, IDX_HBWATCH, 1, 32'h0005_0000, 0, 0);
        b = n_comm;
        repeat (60) @(posedge sys_clk);
        chk("watch off", 32'd0, n_comm - b);
        obj(1, IDX_HBSEND, 0, 32'h1, 0, 0);
        b = n_tick;
        repeat (40) @(posedge sys_clk);
        chk("tick rate", 32'd1, {31'h0, (n_tick - b) inside {9, 10, 11}});
        obj(1, IDX_HBSEND, 0, 32'h0, 0, 0);
        b = n_tick;
        repeat (40) @(posedge sys_clk);
        chk("tick off", 32'd0, n_tick - b);
    endtask
    task automatic t_irq();
        logic [31:0] v;
        hrd(HR_IRQ, v);
        obj(0, IDX_SYNCID, 0, 0, 0, 32'h123);
        chk("irq masked", 32'h0, {31'h0, irq_q});
        hwr(HR_MASK, 32'h3);
        obj(1, IDX_DEVTYPE, 0, 32'h0, 1, 0);
        chk("irq raised", 32'h1, {31'h0, irq_q});
        hrd(HR_IRQ, v);
        chk("irq status", 32'h3, v & 32'h3);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq_q});
        hrd(4'hF, v);
        chk("unmapped read", 32'h0, v);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1;
        repeat (2) @(posedge sys_clk);
        t_fixed();
        t_log();
        t_save();
        t_restore();
        t_timers();
        t_irq();
        wrap_up();
    end
endmodule
